// ---- common/sbar_pkg.sv ----
`default_nettype none
package sbar_pkg;
    // Register byte addresses
    localparam logic [31:0] SBAR_EE_OFF = 32'h0000042c;
    localparam logic [31:0] SBAR_EXP_OFF = 32'h00000430;
    localparam logic [31:0] SBAR_REG_RESET = 32'h00000000;

    // Serial EEPROM register fields
    localparam int EE_ADDR_LSB = 0;
    localparam int EE_DATA_LSB = 16;
    localparam int EE_BUSY_BIT = 24;
    localparam int EE_DONE_BIT = 25;
    localparam int EE_OP_BIT = 26;
    localparam logic EE_OP_WRITE = 1'b0;
    localparam logic EE_OP_READ = 1'b1;

    // Expander register fields
    localparam int EXP_PIN_LSB = 0;
    localparam int EXP_REFRESH_BIT = 24;
    localparam int EXP_TM_BIT = 25;
    localparam int EXP_SEL_LSB = 26;
    localparam int EXP_DONE_BIT = 31;
    localparam int EXP_COUNT = 11;
    localparam logic [3:0] EXP_SEL_MAX = 4'ha;

    // Byte lanes of the Wishbone select
    localparam int LANE_PIN_LO = 0;
    localparam int LANE_PIN_HI = 1;
    localparam int LANE_EE_DATA = 2;
    localparam int LANE_CTRL = 3;

    typedef enum logic [1:0] {
        SBAR_EE_WRITE = 2'h0,
        SBAR_EE_READ = 2'h1,
        SBAR_EXP_REFRESH = 2'h2,
        SBAR_EXP_UPDATE = 2'h3
    } sbar_kind_t;

    // Command handed to the SMBus engine
    typedef struct packed {
        sbar_kind_t kind;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [3:0] sel;
    } sbar_cmd_t;
endpackage
`default_nettype wire

// ---- rtl/sbar_regs.sv ----
// How it works
// - Bits 15:0 of the eeprom register hold the byte address used by the next EEPROM access.
// - Writing the data byte lane while idle launches one EEPROM access of the selected kind at that address.
// - For a write access the byte software wrote is the byte sent to the EEPROM.
// - For a read access the written byte is dropped and the fetched byte is shown once done.
// - Bit 24 reads one while an EEPROM access is in progress and zero when idle.
// - Bit 25 sets when an EEPROM access finishes and is cleared by writing a one.
// - Bit 26 picks the access kind, zero for write and one for read.
// - The expander pin field shows fetched input values and supplied output values.
// - Writes to the pin field are dropped while test mode is clear.
// - In test mode the outputs sent to the expander come from the software pin value.
// - Pin bits that are expander inputs cannot be changed by software.
// - Writing one to bit 24 of the expander register while idle starts a refresh transaction.
// - The refresh bit always reads back as zero.
// - Bit 25 sets test mode, in which core output values are disregarded.
// - Bits 29:26 select expander 0 to 10; other codes are reserved, read the pin field as zero and start no transaction.
// - Bit 31 sets when a refresh or test update finishes and is cleared by writing a one.
//
// The Wishbone interface to the registers was left to the implementer.
`default_nettype none
module sbar_regs
    import sbar_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // SMBus engine link
    input wire logic smb_clk_i,
    input wire logic smb_ack_i,
    input wire logic [15:0] smb_rdata_i,
    output logic smb_req_o,
    output sbar_cmd_t smb_cmd_o,
    // Core expander outputs and direction (1 = output pin)
    input wire logic [EXP_COUNT-1:0][15:0] core_exp_out_i,
    input wire logic [EXP_COUNT-1:0][15:0] exp_out_mask_i
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_REQ = 3'h2,
        ST_REL = 3'h4
    } sbar_state_t;

    sbar_state_t st_reg, st_next;
    sbar_cmd_t cmd_reg, cmd_next;
    logic [15:0] rx_reg, rx_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic [15:0] ee_addr_reg, ee_addr_next;
    logic [7:0] ee_data_reg, ee_data_next;
    logic ee_op_reg, ee_op_next;
    logic ee_done_reg, ee_done_next;
    logic [3:0] x_sel_reg, x_sel_next;
    logic x_tm_reg, x_tm_next;
    logic [15:0] x_tm_val_reg, x_tm_val_next;
    logic x_done_reg, x_done_next;
    logic [15:0] pin_in_reg [EXP_COUNT];
    logic [15:0] pin_in_next [EXP_COUNT];

    // Link inputs come from another domain; the first flop feeds only the second
    logic [1:0] lclk_sync;
    logic lclk_old;
    logic [1:0] lack_sync;
    logic [15:0] lrd_s1, lrd_s2;
    logic lclk_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lclk_sync <= 2'h0;
            lclk_old <= 1'b0;
            lack_sync <= 2'h0;
            lrd_s1 <= 16'h0000;
            lrd_s2 <= 16'h0000;
        end else begin
            lclk_sync <= {lclk_sync[0], smb_clk_i};
            lclk_old <= lclk_sync[1];
            lack_sync <= {lack_sync[0], smb_ack_i};
            lrd_s1 <= smb_rdata_i;
            lrd_s2 <= lrd_s1;
        end
    end

    assign lclk_rise = lclk_sync[1] & ~lclk_old;

    // Bus decode; a write lands on the edge at which ack is seen
    logic hit_ee, hit_x, wr, ee_launch, x_launch, x_refresh, x_pin_wr, done_evt, idle;
    logic x_sel_ok, x_sel_ok_next;
    logic [3:0] sel_idx, sel_idx_next;
    logic [15:0] wmask, x_supplied, x_supplied_next, pin_view;
    logic [31:0] rd_mux;

    assign idle = (st_reg == ST_IDLE);
    assign hit_ee = (wb_adr_i[31:2] == SBAR_EE_OFF[31:2]);
    assign hit_x = (wb_adr_i[31:2] == SBAR_EXP_OFF[31:2]);
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
    assign done_evt = (st_reg == ST_REL) & lclk_rise & ~lack_sync[1];

    always_comb begin
        x_sel_ok = (x_sel_reg <= EXP_SEL_MAX);
        sel_idx = x_sel_ok ? x_sel_reg : 4'h0;
        x_supplied = x_tm_reg ? x_tm_val_reg : core_exp_out_i[sel_idx];
        pin_view = (pin_in_reg[sel_idx] & ~exp_out_mask_i[sel_idx])
                 | (x_supplied & exp_out_mask_i[sel_idx]);
        if (!x_sel_ok) begin
            pin_view = 16'h0000;
        end
        rd_mux = 32'h00000000;
        if (hit_ee) begin
            rd_mux[EE_ADDR_LSB +: 16] = ee_addr_reg;
            rd_mux[EE_DATA_LSB +: 8] = ee_data_reg;
            rd_mux[EE_BUSY_BIT] = ~idle & (cmd_reg.kind inside {SBAR_EE_WRITE, SBAR_EE_READ});
            rd_mux[EE_DONE_BIT] = ee_done_reg;
            rd_mux[EE_OP_BIT] = ee_op_reg;
        end else if (hit_x) begin
            rd_mux[EXP_PIN_LSB +: 16] = pin_view;
            rd_mux[EXP_TM_BIT] = x_tm_reg;
            rd_mux[EXP_SEL_LSB +: 4] = x_sel_reg;
            rd_mux[EXP_DONE_BIT] = x_done_reg;
        end
    end

    always_comb begin
        ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
        dat_next = ack_next ? rd_mux : dat_reg;
        ee_addr_next = ee_addr_reg;
        ee_op_next = ee_op_reg;
        x_sel_next = x_sel_reg;
        x_tm_next = x_tm_reg;
        if (wr & hit_ee) begin
            if (wb_sel_i[0]) begin
                ee_addr_next[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                ee_addr_next[15:8] = wb_dat_i[15:8];
            end
            if (wb_sel_i[LANE_CTRL]) begin
                ee_op_next = wb_dat_i[EE_OP_BIT];
            end
        end
        if (wr & hit_x & wb_sel_i[LANE_CTRL]) begin
            x_sel_next = wb_dat_i[EXP_SEL_LSB +: 4];
            x_tm_next = wb_dat_i[EXP_TM_BIT];
        end
        x_sel_ok_next = (x_sel_next <= EXP_SEL_MAX);
        sel_idx_next = x_sel_ok_next ? x_sel_next : 4'h0;
        x_pin_wr = wr & hit_x & x_tm_reg & (wb_sel_i[LANE_PIN_LO] | wb_sel_i[LANE_PIN_HI]);
        wmask = {{8{wb_sel_i[LANE_PIN_HI]}}, {8{wb_sel_i[LANE_PIN_LO]}}}
              & exp_out_mask_i[sel_idx_next];
        x_tm_val_next = x_tm_val_reg;
        if (x_pin_wr) begin
            x_tm_val_next = (x_tm_val_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
        end
        x_supplied_next = x_tm_next ? x_tm_val_next : core_exp_out_i[sel_idx_next];
        ee_launch = wr & hit_ee & wb_sel_i[LANE_EE_DATA] & idle;
        x_refresh = wr & hit_x & wb_sel_i[LANE_CTRL] & wb_dat_i[EXP_REFRESH_BIT];
        x_launch = (x_refresh | x_pin_wr) & x_sel_ok_next & idle;
    end

    always_comb begin
        st_next = st_reg;
        cmd_next = cmd_reg;
        rx_next = rx_reg;
        unique case (st_reg)
            ST_IDLE: begin
                if (ee_launch) begin
                    st_next = ST_REQ;
                    cmd_next.kind = (ee_op_next == EE_OP_READ) ? SBAR_EE_READ : SBAR_EE_WRITE;
                    cmd_next.addr = ee_addr_next;
                    cmd_next.wdata = {8'h00, wb_dat_i[EE_DATA_LSB +: 8]};
                    cmd_next.sel = 4'h0;
                end else if (x_launch) begin
                    st_next = ST_REQ;
                    cmd_next.kind = x_refresh ? SBAR_EXP_REFRESH : SBAR_EXP_UPDATE;
                    cmd_next.addr = 16'h0000;
                    cmd_next.wdata = x_supplied_next;
                    cmd_next.sel = x_sel_next;
                end
            end
            ST_REQ: begin
                if (lclk_rise & lack_sync[1]) begin
                    st_next = ST_REL;
                    rx_next = lrd_s2;
                end
            end
            ST_REL: begin
                if (done_evt) begin
                    st_next = ST_IDLE;
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always_comb begin
        ee_data_next = ee_data_reg;
        if (ee_launch & (ee_op_next == EE_OP_WRITE)) begin
            ee_data_next = wb_dat_i[EE_DATA_LSB +: 8];
        end
        if (done_evt & (cmd_reg.kind == SBAR_EE_READ)) begin
            ee_data_next = rx_reg[7:0];
        end
        ee_done_next = ee_done_reg;
        if (wr & hit_ee & wb_sel_i[LANE_CTRL] & wb_dat_i[EE_DONE_BIT]) begin
            ee_done_next = 1'b0;
        end
        if (done_evt & (cmd_reg.kind inside {SBAR_EE_WRITE, SBAR_EE_READ})) begin
            ee_done_next = 1'b1;
        end
        x_done_next = x_done_reg;
        if (wr & hit_x & wb_sel_i[LANE_CTRL] & wb_dat_i[EXP_DONE_BIT]) begin
            x_done_next = 1'b0;
        end
        if (done_evt & (cmd_reg.kind inside {SBAR_EXP_REFRESH, SBAR_EXP_UPDATE})) begin
            x_done_next = 1'b1;
        end
    end

    for (genvar gi = 0; gi < EXP_COUNT; gi++) begin : g_pin
        always_comb begin
            pin_in_next[gi] = pin_in_reg[gi];
            if (done_evt & (cmd_reg.kind == SBAR_EXP_REFRESH) & (cmd_reg.sel == 4'(gi))) begin
                pin_in_next[gi] = rx_reg;
            end
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pin_in_reg[gi] <= 16'h0000;
            end else begin
                pin_in_reg[gi] <= pin_in_next[gi];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= ST_IDLE;
            cmd_reg <= '0;
            rx_reg <= 16'h0000;
            ack_reg <= 1'b0;
            dat_reg <= SBAR_REG_RESET;
            ee_addr_reg <= 16'h0000;
            ee_data_reg <= 8'h00;
            ee_op_reg <= 1'b0;
            ee_done_reg <= 1'b0;
            x_sel_reg <= 4'h0;
            x_tm_reg <= 1'b0;
            x_tm_val_reg <= 16'h0000;
            x_done_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            rx_reg <= rx_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            ee_addr_reg <= ee_addr_next;
            ee_data_reg <= ee_data_next;
            ee_op_reg <= ee_op_next;
            ee_done_reg <= ee_done_next;
            x_sel_reg <= x_sel_next;
            x_tm_reg <= x_tm_next;
            x_tm_val_reg <= x_tm_val_next;
            x_done_reg <= x_done_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign smb_req_o = (st_reg == ST_REQ);
    assign smb_cmd_o = cmd_reg;

    AST_EE_LAUNCH: assert property (@(posedge clk_i) disable iff (rst_i)
        ee_launch |=> smb_req_o && smb_cmd_o.addr == $past(ee_addr_next))
        else $error("eeprom launch did not raise request");
    AST_EE_WDATA: assert property (@(posedge clk_i) disable iff (rst_i)
        ee_launch && !ee_op_next |=> smb_cmd_o.kind == SBAR_EE_WRITE
            && smb_cmd_o.wdata[7:0] == $past(wb_dat_i[23:16]))
        else $error("eeprom write byte wrong");
    AST_EE_RDATA: assert property (@(posedge clk_i) disable iff (rst_i)
        done_evt && cmd_reg.kind == SBAR_EE_READ |=> ee_data_reg == $past(rx_reg[7:0]) && ee_done_reg)
        else $error("eeprom read byte not stored");
    AST_EE_BUSY: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_next && hit_ee |=> wb_dat_o[24] == (!$past(idle) && !$past(cmd_reg.kind[1])))
        else $error("busy bit mismatch");
    AST_EE_DONE_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && hit_ee && wb_sel_i[3] && wb_dat_i[25] && !done_evt |=> !ee_done_reg)
        else $error("eeprom done not cleared");
    AST_PIN_WR_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && hit_x && !x_tm_reg |=> $stable(x_tm_val_reg))
        else $error("pin write taken without test mode");
    AST_TM_SUPPLY: assert property (@(posedge clk_i) disable iff (rst_i)
        x_launch && x_tm_next |=> smb_cmd_o.wdata == $past(x_tm_val_next))
        else $error("test value not supplied");
    AST_INPUT_RO: assert property (@(posedge clk_i) disable iff (rst_i)
        x_pin_wr |=> ((x_tm_val_reg ^ $past(x_tm_val_reg)) & ~$past(wmask)) == 16'h0000)
        else $error("input pin bit changed");
    AST_REFRESH: assert property (@(posedge clk_i) disable iff (rst_i)
        x_refresh && x_sel_ok_next && idle |=> smb_req_o && smb_cmd_o.kind == SBAR_EXP_REFRESH)
        else $error("refresh not launched");
    AST_REFRESH_RD0: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_next && hit_x |=> !wb_dat_o[24])
        else $error("refresh bit read nonzero");
    AST_X_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
        done_evt && cmd_reg.kind[1] |=> x_done_reg && smb_req_o == 1'b0)
        else $error("expander done not set");
endmodule
`default_nettype wire

// ---- tb/sbar_engine_model.sv ----
`default_nettype none
module sbar_engine_model
    import sbar_pkg::*;
#(
    parameter logic [15:0] PIN_BASE = 16'hc35a
)(
    // Request from the block
    input wire logic req_i,
    input wire sbar_cmd_t cmd_i,
    // Answer towards the block
    output var logic link_clk_o,
    output var logic ack_o,
    output var logic [15:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [logic [15:0]];
    int lat = 1;
    // Link clock only runs inside a transaction
    task automatic tick();
        #400 link_clk_o = 1'b1;
        #400 link_clk_o = 1'b0;
    endtask
    initial begin
        link_clk_o = 1'b0;
        ack_o = 1'b0;
        rdata_o = 16'h5555;
    end
    always begin
        wait (req_i === 1'b1);
        // Alternate prompt and slow answers
        repeat (lat) tick();
        lat = (lat == 1) ? 4 : 1;
        case (cmd_i.kind)
            SBAR_EE_WRITE: mem[cmd_i.addr] = cmd_i.wdata[7:0];
            SBAR_EE_READ: rdata_o = {8'h00, mem.exists(cmd_i.addr) ? mem[cmd_i.addr] : 8'hff};
            SBAR_EXP_REFRESH: rdata_o = PIN_BASE ^ {12'h000, cmd_i.sel};
            default: rdata_o = ~rdata_o;
        endcase
        ack_o = 1'b1;
        while (req_i === 1'b1) tick();
        ack_o = 1'b0;
        // Read data is not held once ack drops
        rdata_o = ~rdata_o;
        repeat (3) tick();
    end
endmodule
`default_nettype wire

// ---- tb/smbus_sideband_access_regs_test.sv ----
`default_nettype none
module smbus_sideband_access_regs_test
    import sbar_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] PIN_BASE = 16'hc35a;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, wb_dat_o, r;
    logic [3:0] sel = 4'h0;
    logic wb_ack_o, smb_req_o, smb_clk_i, smb_ack_i;
    logic [15:0] smb_rdata_i;
    sbar_cmd_t smb_cmd_o;
    logic [EXP_COUNT-1:0][15:0] core_out = '0, out_mask = {EXP_COUNT{16'h0ff0}};
    logic [15:0] in_last [EXP_COUNT] = '{default: 16'h0000};
    int n_errors = 0, n_checks = 0;
    always #50 clk_i = ~clk_i;
    sbar_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .smb_clk_i(smb_clk_i), .smb_ack_i(smb_ack_i),
        .smb_rdata_i(smb_rdata_i), .smb_req_o(smb_req_o), .smb_cmd_o(smb_cmd_o),
        .core_exp_out_i(core_out), .exp_out_mask_i(out_mask));
    sbar_engine_model #(.PIN_BASE(PIN_BASE)) i_model (.req_i(smb_req_o), .cmd_i(smb_cmd_o),
        .link_clk_o(smb_clk_i), .ack_o(smb_ack_i), .rdata_o(smb_rdata_i));
    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold until ack is sampled high, then release
    task automatic wb(input logic w, input logic [31:0] a, input logic [3:0] s,
            input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        // Ack is sampled at the rising edge; data is taken and the request dropped there
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk({31'h0, wb_ack_o}, 32'h1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, s, d, q);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        wb(1'b0, a, 4'hf, 32'h0, q);
    endtask
    task automatic wait_bit(input logic [31:0] a, input int b, input logic v);
        int n;
        n = 0;
        do begin
            rd(a, r);
            n++;
        end while (r[b] !== v && n < 200);
        chk({31'h0, r[b]}, {31'h0, v});
    endtask
    function automatic logic [15:0] pins(input int s, input logic [15:0] outv);
        return (out_mask[s] & outv) | (~out_mask[s] & in_last[s]);
    endfunction
    task automatic t_reset();
        rd(SBAR_EE_OFF, r);
        chk(r, SBAR_REG_RESET);
        rd(SBAR_EXP_OFF, r);
        chk(r, SBAR_REG_RESET);
        wr(32'h0000_0500, 4'hf, 32'hffff_ffff);
        rd(32'h0000_0500, r);
        chk(r, 32'h0);
        for (int k = 0; k < EXP_COUNT; k++) core_out[k] <= 16'ha000 | 16'(k * 16);
    endtask
    task automatic t_eeprom();
        wr(SBAR_EE_OFF, 4'hf, {5'h0, EE_OP_WRITE, 2'b00, 8'h5a, 16'hffff});
        rd(SBAR_EE_OFF, r);
        chk(r, {5'h0, EE_OP_WRITE, 2'b01, 8'h5a, 16'hffff});
        wait_bit(SBAR_EE_OFF, EE_BUSY_BIT, 1'b0);
        chk({31'h0, r[EE_DONE_BIT]}, 32'h1);
        wr(SBAR_EE_OFF, 4'hf, {5'h0, EE_OP_READ, 2'b10, 8'hc3, 16'hffff});
        wait_bit(SBAR_EE_OFF, EE_BUSY_BIT, 1'b0);
        chk(r, {5'h0, EE_OP_READ, 2'b10, 8'h5a, 16'hffff});
        wr(SBAR_EE_OFF, 4'b1011, {5'h0, EE_OP_WRITE, 2'b10, 8'h00, 16'h1234});
        rd(SBAR_EE_OFF, r);
        chk(r, {5'h0, EE_OP_WRITE, 2'b00, 8'h5a, 16'h1234});
    endtask
    task automatic t_expander();
        wr(SBAR_EXP_OFF, 4'b1011, {2'b00, 4'd3, 2'b00, 8'h0, 16'hffff});
        rd(SBAR_EXP_OFF, r);
        chk(r, {2'b00, 4'd3, 2'b00, 8'h0, pins(3, core_out[3])});
        for (int k = 0; k < EXP_COUNT; k++) begin
            wr(SBAR_EXP_OFF, 4'b1000, {2'b00, 4'(k), 2'b01, 24'h0});
            wait_bit(SBAR_EXP_OFF, EXP_DONE_BIT, 1'b1);
            in_last[k] = PIN_BASE ^ 16'(k);
            chk(r, {2'b10, 4'(k), 2'b00, 8'h0, pins(k, core_out[k])});
            wr(SBAR_EXP_OFF, 4'b1000, {2'b10, 4'(k), 2'b00, 24'h0});
        end
        wr(SBAR_EXP_OFF, 4'b1000, {2'b00, 4'd11, 2'b01, 24'h0});
        rd(SBAR_EXP_OFF, r);
        chk(r, {2'b00, 4'd11, 2'b00, 24'h0});
        chk({31'h0, smb_req_o}, 32'h0);
        // Test mode must be on before a pin write is taken
        wr(SBAR_EXP_OFF, 4'b1000, {2'b00, 4'd3, 2'b10, 24'h0});
        rd(SBAR_EXP_OFF, r);
        chk(r, {2'b00, 4'd3, 2'b10, 8'h0, pins(3, 16'h0000)});
        wr(SBAR_EXP_OFF, 4'b1011, {2'b00, 4'd3, 2'b10, 8'h0, 16'hffff});
        wait_bit(SBAR_EXP_OFF, EXP_DONE_BIT, 1'b1);
        chk(r, {2'b10, 4'd3, 2'b10, 8'h0, pins(3, 16'hffff)});
        chk({30'h0, smb_cmd_o.kind}, {30'h0, SBAR_EXP_UPDATE});
        chk({16'h0, smb_cmd_o.wdata & out_mask[3]}, {16'h0, out_mask[3]});
        core_out[3] <= 16'h0055;
        rd(SBAR_EXP_OFF, r);
        chk(r, {2'b10, 4'd3, 2'b10, 8'h0, pins(3, 16'hffff)});
        wr(SBAR_EXP_OFF, 4'b1000, {2'b10, 4'd3, 2'b00, 24'h0});
        rd(SBAR_EXP_OFF, r);
        chk(r, {2'b00, 4'd3, 2'b00, 8'h0, pins(3, 16'h0055)});
    endtask
    initial begin
        #(100 * 30000);
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_eeprom();
        t_expander();
        print_verdict();
    end
endmodule
`default_nettype wire
